// ### lfr_defines.vh
// Constants shared by the firmware-memory read target and its testbench.
// Assumes it is included by bare name from every design file that needs it.
`ifndef LFR_DEFINES_VH
`define LFR_DEFINES_VH

// ----------------------------------------------------------------------------
// Cycle start codes and fixed nibbles
// ----------------------------------------------------------------------------
`define LFR_START_READ 4'hd
`define LFR_START_WRITE 4'he
`define LFR_NIB_ONES 4'hf
`define LFR_NIB_READY_SYNC 4'h0

// ----------------------------------------------------------------------------
// Size field codes
// ----------------------------------------------------------------------------
`define LFR_SIZE_1 4'h0
`define LFR_SIZE_2 4'h1
`define LFR_SIZE_4 4'h2
`define LFR_SIZE_16 4'h4
`define LFR_SIZE_128 4'h7

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define LFR_ADDR_NIBBLES 3'h7
`define LFR_ADDR_LAST 3'h6
`define LFR_ADDR_W 28
`define LFR_MEM_ADDR_W 21
`define LFR_ARRAY_SEL_BIT 22
`define LFR_ID_W 4

// ----------------------------------------------------------------------------
// Reset values of the synchronised pins
// ----------------------------------------------------------------------------
`define LFR_BUS_SYNC_INIT 6'h3f
`define LFR_PIN_SYNC_INIT 7'h03

`endif

// ### lfr_sync.v
// Three-stage synchroniser with an agreement filter for pin inputs.
// Assumes the sampling clock is much faster than any pin change.
`timescale 1ns/1ps

module lfr_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Asynchronous pins
   input wire [W-1:0] d,
   // Filtered level
   output reg [W-1:0] q
);

   reg [W-1:0] stage1;
   reg [W-1:0] stage2;
   reg [W-1:0] stage3;
   integer i;

   // ----------------------------------------------------------------------------
   // Sampling chain and agreement filter
   // ----------------------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
         q <= INIT;
      end
      else
      begin
         stage1 <= d;
         stage2 <= stage1;
         stage3 <= stage2;
         for (i = 0; i < W; i = i + 1)
         begin
            if (stage2[i] == stage3[i])
            begin
               q[i] <= stage3[i];
            end
         end
      end
   end

endmodule // lfr_sync

// ### lfr_target.v
// Firmware-memory read target of a low-pin-count flash interface.
// Assumes the bus clock is far slower than sys_clk, and that the memory
// answers each byte request before the next bus clock edge.
`timescale 1ns/1ps
`include "lfr_defines.vh"

module lfr_target #(
   parameter ID_W = `LFR_ID_W,
   parameter MEM_ADDR_W = `LFR_MEM_ADDR_W
) (
   // System clock and reset
   input wire sys_clk,
   input wire rst,
   // Bus pins from the host
   input wire bus_clk,
   input wire bus_frame_n,
   input wire [3:0] bus_data_in,
   // Bus data drive, enable low while driving
   output reg [3:0] bus_data_out,
   output reg bus_data_oe_n,
   // Device pins
   input wire reset_n,
   input wire init_n,
   input wire protect_or_mode_pin_hv,
   input wire [ID_W-1:0] strap_select_id,
   // Internal engine state
   input wire program_busy,
   // Memory read port
   output reg mem_rd_req,
   output reg [MEM_ADDR_W-1:0] mem_addr,
   output reg mem_array_sel,
   input wire mem_rd_ack,
   input wire [7:0] mem_rd_data,
   // Status
   output reg auto_increment_program_mode,
   output reg standby,
   output reg cycle_active
);

   // ----------------------------------------------------------------------------
   // Cycle states
   // ----------------------------------------------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_START = 3'h1;
   localparam ST_ADDR = 3'h2;
   localparam ST_SIZE = 3'h3;
   localparam ST_TURN = 3'h4;
   localparam ST_SYNC = 3'h5;
   localparam ST_DATA = 3'h6;
   localparam ST_RELEASE = 3'h7;

   // ----------------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------------
   function read_size_ok;
      input [3:0] code;
      begin
         read_size_ok = (code == `LFR_SIZE_1) || (code == `LFR_SIZE_2) ||
                        (code == `LFR_SIZE_4) || (code == `LFR_SIZE_16) ||
                        (code == `LFR_SIZE_128);
      end
   endfunction

   function [MEM_ADDR_W-1:0] byte_addr;
      input [MEM_ADDR_W-1:0] base;
      input [3:0] code;
      input [6:0] idx;
      reg [MEM_ADDR_W-1:0] mask;
      begin
         mask = {MEM_ADDR_W{1'b1}} << code[2:0];
         byte_addr = (base & mask) | {{(MEM_ADDR_W-7){1'b0}}, idx};
      end
   endfunction

   // ----------------------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------------------
   wire [5:0] bus_f;
   wire [ID_W+2:0] pin_f;
   wire bus_clk_f;
   wire frame_n_f;
   wire [3:0] data_f;
   wire reset_n_f;
   wire init_n_f;
   wire hv_f;
   wire [ID_W-1:0] id_f;

   lfr_sync #(
      .W(6),
      .INIT(`LFR_BUS_SYNC_INIT)
   ) u_bus_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .d({bus_data_in, bus_frame_n, bus_clk}),
      .q(bus_f)
   );

   lfr_sync #(
      .W(ID_W + 3),
      .INIT(`LFR_PIN_SYNC_INIT)
   ) u_pin_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .d({strap_select_id, protect_or_mode_pin_hv, init_n, reset_n}),
      .q(pin_f)
   );

   assign bus_clk_f = bus_f[0];
   assign frame_n_f = bus_f[1];
   assign data_f = bus_f[5:2];
   assign reset_n_f = pin_f[0];
   assign init_n_f = pin_f[1];
   assign hv_f = pin_f[2];
   assign id_f = pin_f[ID_W+2:3];

   // ----------------------------------------------------------------------------
   // Cycle state and datapath
   // ----------------------------------------------------------------------------
   reg bus_clk_prev;
   reg [2:0] state;
   reg [3:0] start_code;
   reg [`LFR_ADDR_W-1:0] addr;
   reg [2:0] addr_cnt;
   reg [3:0] size_code;
   reg [8:0] nib_cnt;
   reg [8:0] nib_total;
   reg [6:0] byte_idx;
   reg [7:0] data_byte;
   reg [3:0] hi_hold;

   wire bus_edge;
   wire hold_reset;
   wire [`LFR_ADDR_W-1:0] next_addr;

   assign bus_edge = bus_clk_f & ~bus_clk_prev;
   assign hold_reset = rst | ~reset_n_f | ~init_n_f | hv_f;
   assign next_addr = {addr[`LFR_ADDR_W-5:0], data_f};

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         bus_clk_prev <= 1'b1;
      end
      else
      begin
         bus_clk_prev <= bus_clk_f;
      end
   end

   always @(posedge sys_clk)
   begin
      if (hold_reset)
      begin
         state <= ST_IDLE;
         bus_data_out <= `LFR_NIB_ONES;
         bus_data_oe_n <= 1'b1;
         start_code <= 4'h0;
         addr <= {`LFR_ADDR_W{1'b0}};
         addr_cnt <= 3'h0;
         size_code <= 4'h0;
         nib_cnt <= 9'h000;
         nib_total <= 9'h000;
         byte_idx <= 7'h00;
         data_byte <= 8'h00;
         hi_hold <= 4'h0;
         mem_rd_req <= 1'b0;
         mem_addr <= {MEM_ADDR_W{1'b0}};
         mem_array_sel <= 1'b0;
      end
      else
      begin
         mem_rd_req <= 1'b0;
         if (mem_rd_ack)
         begin
            data_byte <= mem_rd_data;
         end
         if (bus_edge)
         begin
            if (!frame_n_f)
            begin
               state <= ST_START;
               start_code <= data_f;
               bus_data_oe_n <= 1'b1;
            end
            else
            begin
               case (state)
                  ST_START:
                  begin
                     if ((start_code == `LFR_START_READ) ||
                         (start_code == `LFR_START_WRITE))
                     begin
                        if (data_f == id_f)
                        begin
                           state <= ST_ADDR;
                           addr_cnt <= 3'h0;
                        end
                        else
                        begin
                           state <= ST_IDLE;
                        end
                     end
                     else
                     begin
                        state <= ST_IDLE;
                     end
                  end
                  ST_ADDR:
                  begin
                     addr <= next_addr;
                     if (addr_cnt == `LFR_ADDR_LAST)
                     begin
                        state <= ST_SIZE;
                     end
                     else
                     begin
                        addr_cnt <= addr_cnt + 3'h1;
                     end
                  end
                  ST_SIZE:
                  begin
                     if ((start_code == `LFR_START_READ) && read_size_ok(data_f))
                     begin
                        state <= ST_TURN;
                        size_code <= data_f;
                        nib_total <= 9'h002 << data_f[2:0];
                        byte_idx <= 7'h00;
                        mem_rd_req <= 1'b1;
                        mem_addr <= byte_addr(addr[MEM_ADDR_W-1:0], data_f, 7'h00);
                        mem_array_sel <= addr[`LFR_ARRAY_SEL_BIT];
                     end
                     else
                     begin
                        state <= ST_IDLE;
                     end
                  end
                  ST_TURN:
                  begin
                     bus_data_out <= `LFR_NIB_ONES;
                     bus_data_oe_n <= 1'b0;
                     state <= ST_SYNC;
                  end
                  ST_SYNC:
                  begin
                     bus_data_out <= `LFR_NIB_READY_SYNC;
                     nib_cnt <= 9'h000;
                     state <= ST_DATA;
                  end
                  ST_DATA:
                  begin
                     if (nib_cnt == nib_total)
                     begin
                        bus_data_out <= `LFR_NIB_ONES;
                        state <= ST_RELEASE;
                     end
                     else
                     begin
                        nib_cnt <= nib_cnt + 9'h001;
                        if (!nib_cnt[0])
                        begin
                           bus_data_out <= data_byte[3:0];
                           hi_hold <= data_byte[7:4];
                           if (nib_cnt + 9'h002 < nib_total)
                           begin
                              byte_idx <= byte_idx + 7'h01;
                              mem_rd_req <= 1'b1;
                              mem_addr <= byte_addr(addr[MEM_ADDR_W-1:0], size_code,
                                                    byte_idx + 7'h01);
                           end
                        end
                        else
                        begin
                           bus_data_out <= hi_hold;
                        end
                     end
                  end
                  ST_RELEASE:
                  begin
                     bus_data_oe_n <= 1'b1;
                     state <= ST_IDLE;
                  end
                  default:
                  begin
                     state <= ST_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         auto_increment_program_mode <= 1'b0;
         standby <= 1'b0;
         cycle_active <= 1'b0;
      end
      else
      begin
         auto_increment_program_mode <= hv_f;
         standby <= (state == ST_IDLE) && frame_n_f && !program_busy;
         cycle_active <= (state != ST_IDLE);
      end
   end

endmodule // lfr_target

// ### lfr_target_sva.sv
// Port checker of the firmware-memory read target.
// Assumes bus clock half-periods of at least four system clocks.
`timescale 1ns/1ps

module lfr_target_sva #(
   parameter ID_W = 4,
   parameter MEM_ADDR_W = 21
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Bus pins
   input wire bus_clk,
   input wire bus_frame_n,
   input wire [3:0] bus_data_in,
   input wire [3:0] bus_data_out,
   input wire bus_data_oe_n,
   // Device pins and engine state
   input wire reset_n,
   input wire init_n,
   input wire protect_or_mode_pin_hv,
   input wire [ID_W-1:0] strap_select_id,
   input wire program_busy,
   // Memory port
   input wire mem_rd_req,
   input wire [MEM_ADDR_W-1:0] mem_addr,
   input wire mem_array_sel,
   input wire mem_rd_ack,
   input wire [7:0] mem_rd_data,
   // Status
   input wire auto_increment_program_mode,
   input wire standby,
   input wire cycle_active
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   sys_reset_a: assert property ($fell(rst) |-> bus_data_oe_n && !mem_rd_req && !cycle_active)
      else $error("outputs not idle after reset");
   pin_reset_a: assert property ((!reset_n || !init_n) [*8] |-> bus_data_oe_n && !cycle_active)
      else $error("reset pin did not idle the bus");
   mode_hold_a: assert property (protect_or_mode_pin_hv [*8] |->
      auto_increment_program_mode && bus_data_oe_n)
      else $error("mode pin not followed");
   busy_standby_a: assert property (program_busy |=> !standby)
      else $error("standby while busy");
   idle_standby_a: assert property ((bus_frame_n && !program_busy && !cycle_active && reset_n
      && init_n && !protect_or_mode_pin_hv) [*8] |=> standby)
      else $error("no standby when idle");
   req_pulse_a: assert property (mem_rd_req |=> !mem_rd_req)
      else $error("byte request longer than one cycle");
   drive_active_a: assert property (!bus_data_oe_n |-> cycle_active || $past(cycle_active))
      else $error("bus driven outside a cycle");
   abort_release_a: assert property ($rose(bus_clk) && !bus_frame_n |-> ##[1:10] bus_data_oe_n)
      else $error("bus not released on abort");
   take_over_a: assert property ($fell(bus_data_oe_n) |-> bus_data_out == 4'hf)
      else $error("takeover nibble not ones");
   ready_sync_a: assert property ($fell(bus_data_oe_n) |->
      (bus_data_out == 4'hf) [*8] ##[1:20] bus_data_out == 4'h0)
      else $error("ready sync missing");
   release_ones_a: assert property ($rose(bus_data_oe_n) && bus_frame_n && reset_n && init_n
      && !protect_or_mode_pin_hv |-> $past(bus_data_out) == 4'hf)
      else $error("release not preceded by ones");

   cover property ($fell(bus_data_oe_n));
   cover property ($rose(bus_clk) && !bus_frame_n && !bus_data_oe_n);
   cover property (mem_rd_req && mem_array_sel);
endmodule // lfr_target_sva

bind lfr_target lfr_target_sva #(.ID_W(ID_W), .MEM_ADDR_W(MEM_ADDR_W)) chk (
   .sys_clk(sys_clk), .rst(rst), .bus_clk(bus_clk), .bus_frame_n(bus_frame_n),
   .bus_data_in(bus_data_in), .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
   .reset_n(reset_n), .init_n(init_n), .protect_or_mode_pin_hv(protect_or_mode_pin_hv),
   .strap_select_id(strap_select_id), .program_busy(program_busy), .mem_rd_req(mem_rd_req),
   .mem_addr(mem_addr), .mem_array_sel(mem_array_sel), .mem_rd_ack(mem_rd_ack),
   .mem_rd_data(mem_rd_data), .auto_increment_program_mode(auto_increment_program_mode),
   .standby(standby), .cycle_active(cycle_active));

// ### lfr_host_model.sv
// Host bus master model: clocks the bus only inside cycles, drives frame and nibbles.
// Assumes the bench resolves the shared nibble wire and returns it on lad.
`timescale 1ns/1ps

module lfr_host_model (
   // System clock and wire
   input wire sys_clk,
   input wire [3:0] lad,
   // Host pins
   output reg bus_clk = 1'b1,
   output reg bus_frame_n = 1'b1,
   output reg [3:0] host_data = 4'hf,
   output reg host_drive = 1'b0
);
   reg [3:0] seen [0:271];
   integer n_seen = 0;

   // One bus clock: fields change just after a rise and are taken at the next rise.
   task tick(input [3:0] d, input drv, input fr);
      begin
         @(posedge sys_clk);
         bus_frame_n <= fr;
         host_data <= d;
         host_drive <= drv;
         repeat (8) @(posedge sys_clk);
         bus_clk <= 1'b0;
         repeat (8) @(posedge sys_clk);
         seen[n_seen] = lad;
         n_seen = n_seen + 1;
         bus_clk <= 1'b1;
      end
   endtask

   task cycle(input [3:0] st, input [3:0] id, input [27:0] a, input [3:0] sz, input integer nr);
      integer i;
      begin
         n_seen = 0;
         tick(4'h5, 1'b1, 1'b0);
         tick(st, 1'b1, 1'b0);
         tick(id, 1'b1, 1'b1);
         for (i = 6; i >= 0; i = i - 1)
            tick(a[i*4 +: 4], 1'b1, 1'b1);
         tick(sz, 1'b1, 1'b1);
         tick(4'hf, 1'b1, 1'b1);
         for (i = 0; i < nr; i = i + 1)
            tick(4'hf, 1'b0, 1'b1);
      end
   endtask
endmodule // lfr_host_model

// ### test_lpc_firmware_read_target.sv
// Self-checking bench of the firmware-memory read target against a host model.
// Assumes the design, checker and host model files are compiled before it.
`timescale 1ns/1ps
`include "lfr_defines.vh"
`define CHK(nm, e, g) \
   begin \
      n_checks = n_checks + 1; \
      if ((g) !== (e)) \
      begin \
         num_errors = num_errors + 1; \
         $display("[FAIL] %s expected %h seen %h", nm, e, g); \
      end \
   end

module test_lpc_firmware_read_target;
   reg sys_clk = 1'b0;
   reg rst = 1'b1;
   reg reset_n = 1'b1;
   reg init_n = 1'b1;
   reg hv = 1'b0;
   reg busy = 1'b0;
   reg mem_rd_ack = 1'b0;
   reg [7:0] mem_rd_data = 8'h00;
   reg [3:0] float_pat = 4'ha;
   reg [3:0] strap = 4'h3;
   integer n_drive = 0;
   integer num_errors = 0;
   integer n_checks = 0;
   integer cycles = 0;
   wire bus_clk, bus_frame_n, host_drive, oe_n, mem_rd_req, mem_array_sel, aip, standby, active;
   wire [3:0] host_data, lad, out;
   wire [20:0] mem_addr;

   // A released wire shows a pattern that changes every cycle.
   assign lad = !oe_n ? out : host_drive ? host_data : float_pat;

   always #2.5 sys_clk = ~sys_clk;

   lfr_host_model host (.sys_clk(sys_clk), .lad(lad), .bus_clk(bus_clk),
      .bus_frame_n(bus_frame_n), .host_data(host_data), .host_drive(host_drive));

   lfr_target dut (.sys_clk(sys_clk), .rst(rst), .bus_clk(bus_clk), .bus_frame_n(bus_frame_n),
      .bus_data_in(lad), .bus_data_out(out), .bus_data_oe_n(oe_n), .reset_n(reset_n),
      .init_n(init_n), .protect_or_mode_pin_hv(hv), .strap_select_id(strap), .program_busy(busy),
      .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_array_sel(mem_array_sel),
      .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .auto_increment_program_mode(aip),
      .standby(standby), .cycle_active(active));

   function [7:0] mem_byte(input [20:0] a);
      mem_byte = a[7:0] ^ a[15:8] ^ {a[20:16], 3'h5};
   endfunction

   task finish_test;
      begin
         if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   always @(posedge sys_clk)
   begin
      float_pat <= ~float_pat;
      mem_rd_ack <= mem_rd_req;
      mem_rd_data <= mem_byte(mem_addr);
      cycles = cycles + 1;
      if (oe_n === 1'b0)
         n_drive = n_drive + 1;
      if (host_drive)
         `CHK("bus_owner", 1'b1, oe_n)
      if (cycles == 40000)
      begin
         num_errors = num_errors + 1;
         finish_test;
      end
   end

   task check_read(input [3:0] sz, input [27:0] a);
      integer i, nb;
      reg [20:0] base;
      reg [7:0] b;
      begin
         nb = 1 << sz;
         base = a[20:0] & ~((21'h1 << sz) - 21'h1);
         host.cycle(`LFR_START_READ, strap, a, sz, 2 * nb + 4);
         `CHK("turnaround", 4'hf, host.seen[12])
         `CHK("ready_sync", 4'h0, host.seen[13])
         for (i = 0; i < nb; i = i + 1)
         begin
            b = mem_byte(base + i[20:0]);
            `CHK("data_lo", b[3:0], host.seen[14 + 2 * i])
            `CHK("data_hi", b[7:4], host.seen[15 + 2 * i])
         end
         `CHK("tar_ones", 4'hf, host.seen[14 + 2 * nb])
         `CHK("released", 1'b1, oe_n)
         `CHK("array_sel", a[22], mem_array_sel)
      end
   endtask

   task check_quiet(input [3:0] st, input [3:0] id, input [3:0] sz);
      integer d0;
      begin
         d0 = n_drive;
         host.cycle(st, id, 28'h0400010, sz, 6);
         `CHK("no_drive", d0, n_drive)
      end
   endtask

   task pin_reset(input sel);
      begin
         host.cycle(`LFR_START_READ, 4'h3, 28'h0400000, `LFR_SIZE_16, 6);
         reset_n <= sel;
         init_n <= !sel;
         repeat (12) @(posedge sys_clk);
         `CHK("pin_reset_bus", 1'b1, oe_n)
         `CHK("pin_reset_idle", 1'b0, active)
         reset_n <= 1'b1;
         init_n <= 1'b1;
         repeat (8) @(posedge sys_clk);
      end
   endtask

   initial
   begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (12) @(posedge sys_clk);
      `CHK("standby", 1'b1, standby)
      busy <= 1'b1;
      repeat (2) @(posedge sys_clk);
      `CHK("busy_standby", 1'b0, standby)
      busy <= 1'b0;
      check_read(`LFR_SIZE_1, 28'h0400123);
      check_read(`LFR_SIZE_2, 28'h0001f7b);
      check_read(`LFR_SIZE_4, 28'h0001f7b);
      check_read(`LFR_SIZE_16, 28'h0001f7b);
      check_read(`LFR_SIZE_128, 28'h0401f7b);
      check_quiet(`LFR_START_READ, 4'h4, `LFR_SIZE_1);
      check_quiet(`LFR_START_READ, 4'h3, 4'h3);
      check_quiet(4'h5, 4'h3, `LFR_SIZE_1);
      check_quiet(`LFR_START_WRITE, 4'h3, `LFR_SIZE_1);
      host.cycle(`LFR_START_READ, 4'h3, 28'h0400000, `LFR_SIZE_128, 6);
      host.tick(4'hf, 1'b0, 1'b0);
      repeat (8) @(posedge sys_clk);
      `CHK("abort_release", 1'b1, oe_n)
      check_read(`LFR_SIZE_4, 28'h0400040);
      pin_reset(1'b0);
      pin_reset(1'b1);
      hv <= 1'b1;
      strap <= 4'hc;
      repeat (12) @(posedge sys_clk);
      `CHK("mode_on", 1'b1, aip)
      hv <= 1'b0;
      repeat (12) @(posedge sys_clk);
      `CHK("mode_off", 1'b0, aip)
      check_read(`LFR_SIZE_2, 28'h0400002);
      finish_test;
   end
endmodule // test_lpc_firmware_read_target
